// ---- hw/monitor_adc_sequencer.sv ----
// converter measurement sequencer with its APB register file
// assumes the converter code pin is asynchronous and stable by the hold end
//
// Summary of operation
// - each channel enabled individually by select/count
// - count sets cells in use, drop from 16
// - unused cells masked, comparators powered down
// - idle mux rests on channel equal count
// - averaging of 2 to 32, or single
// - mean as one 16-bit result, no samples
// - cells, then external inputs, then internals in order
// - cells converted from highest down to lowest
// - cycled mode sweeps all cells once per pass for every pass, then all inputs the same way; internals are not cycled
// - non-cycled mode finishes one channel first
// - first and later periods timed separately
// - cycled later periods of cells and inputs equal first periods
// - non-cycled later: cells hv, inputs general
// - internal later periods: core and die temp general, others hv
// - digital temperature never averaged, first period fixed 50 us
// - monitor enable picks two or one conversions
// - command write starts the sequence
// - full scale code means twice reference
// - each conversion holds fixed 3.44 us
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module monitor_adc_sequencer
  import adc_seq_pkg::*;
(
  input wire logic pclk, // clock, 20 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  input wire logic [13:0] adc_code_in, // converter code pin
  output afe_ctrl_s afe_ctrl, // mux and hold control
  output cell_guard_s cell_guard, // fault mask and comparator power
  output logic busy // sequence running
);

  // ****************************************
  // register file
  // ****************************************
  logic [4:0] cell_count_reg;
  logic [31:0] chan_sel_reg;
  logic [23:0] averaging_config_reg;
  logic [12:0] cell_period_reg;
  logic [12:0] ext_input_period_reg;
  logic [28:0] selftest_period_reg;
  logic [28:0] internal_period_reg;
  logic selftest_config_reg;
  logic [7:0] power_config_reg;

  logic wr_en;
  logic start_req;
  logic result_hit;
  logic [4:0] result_index;
  logic reg_hit;

  assign wr_en = psel & penable & pwrite;
  assign result_index = 5'(paddr[6:2]);
  assign result_hit = paddr >= RESULT_BASE_OFS && result_index < 5'(NUM_SLOTS) && paddr[1:0] == 2'b00;

  always_comb begin
    unique case (paddr)
      CMD_OFS, CELL_COUNT_OFS, CHAN_SEL_OFS, AVG_CFG_OFS, CELL_PER_OFS, EXT_PER_OFS,
      SELFTEST_PER_OFS, INTERNAL_PER_OFS, SELFTEST_CFG_OFS, POWER_CFG_OFS: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  end

  // every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(reg_hit | result_hit);

  assign start_req = wr_en && paddr == CMD_OFS && pwdata[CMD_START_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_count_reg <= CELL_COUNT_RST;
      chan_sel_reg <= CHAN_SEL_RST;
      averaging_config_reg <= AVG_CFG_RST;
      cell_period_reg <= CELL_PER_RST;
      ext_input_period_reg <= PER_RST;
      selftest_period_reg <= {PER_RST, 3'h0, PER_RST};
      internal_period_reg <= {PER_RST, 3'h0, PER_RST};
      selftest_config_reg <= 1'b0;
      power_config_reg <= POWER_CFG_RST;
    end else if (wr_en) begin
      unique case (paddr)
        CELL_COUNT_OFS: cell_count_reg <= pwdata[4:0];
        CHAN_SEL_OFS: chan_sel_reg <= {pwdata[31:16], 2'b00, pwdata[13:0]};
        AVG_CFG_OFS: averaging_config_reg <= {pwdata[23:8], 4'h0, pwdata[3:0]};
        CELL_PER_OFS: cell_period_reg <= pwdata[12:0];
        EXT_PER_OFS: ext_input_period_reg <= pwdata[12:0];
        SELFTEST_PER_OFS: selftest_period_reg <= {pwdata[28:16], 3'h0, pwdata[12:0]};
        INTERNAL_PER_OFS: internal_period_reg <= {pwdata[28:16], 3'h0, pwdata[12:0]};
        SELFTEST_CFG_OFS: selftest_config_reg <= pwdata[MON_EN_BIT];
        POWER_CFG_OFS: power_config_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // configuration decode
  // ****************************************
  logic cycled_average_bit;
  logic [2:0] ovs_code;
  logic [7:0] hv_later_period;
  logic [7:0] general_later_period;
  logic stack_voltage_monitor_enable;
  logic [5:0] ovs_count;
  logic [NUM_SLOTS-1:0] slot_en;
  logic [15:0] cell_in_use;

  assign cycled_average_bit = averaging_config_reg[AVG_CYCLE_BIT];
  // codes 1..5 give 2..32, others single
  assign ovs_code = (averaging_config_reg[2:0] > OVS_MAX_CODE) ? 3'h0 : averaging_config_reg[2:0];
  assign ovs_count = 6'(1) << ovs_code;
  assign hv_later_period = averaging_config_reg[AVG_HV_LSB +: 8];
  assign general_later_period = averaging_config_reg[AVG_GEN_LSB +: 8];
  assign stack_voltage_monitor_enable = selftest_config_reg;

  always_comb begin
    cell_in_use = '0;
    slot_en = '0;
    for (int c = 1; c <= 16; c++) begin
      cell_in_use[c-1] = 5'(c) <= cell_count_reg;
      // slot 0 is cell 16, slot 15 cell 1
      slot_en[16-c] = cell_in_use[c-1] & chan_sel_reg[SEL_CELL_LSB + c - 1];
    end
    for (int a = 0; a < 8; a++) begin
      slot_en[SLOT_AUX0 + a] = chan_sel_reg[a];
    end
    slot_en[SLOT_DTEMP] = chan_sel_reg[SEL_DTEMP_BIT];
    slot_en[SLOT_ATEMP] = chan_sel_reg[SEL_ATEMP_BIT];
    slot_en[SLOT_CORE] = chan_sel_reg[SEL_CORE_BIT];
    slot_en[SLOT_REF] = chan_sel_reg[SEL_REF_BIT];
    slot_en[SLOT_MODULE] = chan_sel_reg[SEL_MODULE_BIT];
    slot_en[SLOT_NEGRAIL] = chan_sel_reg[SEL_NEGRAIL_BIT];
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4:0] find_slot(input logic [NUM_SLOTS-1:0] en, input logic [4:0] from,
                                           input logic [4:0] last);
    logic [4:0] r;
    r = SLOT_NONE;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (5'(i) >= from && 5'(i) <= last && en[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : find_slot

  function automatic logic [15:0] units(input logic [12:0] field);
    logic [15:0] c;
    c = 16'(field) * PERIOD_UNIT_CYC;
    return (c == 16'h0000) ? 16'h0001 : c;
  endfunction : units

  // ****************************************
  // sequencer
  // ****************************************
  seq_state_e state_reg;
  logic [1:0] group_reg;
  logic [4:0] slot_reg;
  logic [4:0] ptr_reg;
  logic [5:0] pass_reg;
  logic [15:0] timer_reg;
  logic [13:0] adc_meta_reg;
  logic [13:0] adc_sync_reg;
  logic [ACC_W-1:0] acc_rd;
  logic [4:0] group_last;
  logic [4:0] group_first_next;
  logic [4:0] found;
  logic group_cycled;
  logic [5:0] need;
  logic [2:0] shift_k;
  logic [4:0] acq_slot;
  logic acq_later;
  logic [15:0] acq_cycles;
  logic [ACC_W-1:0] sum;
  logic [ACC_W+1:0] scaled;
  logic final_sample;
  logic mem_we;
  logic [ACC_W-1:0] mem_wd;

  assign group_last = (group_reg == 2'd0) ? CELL_LAST : (group_reg == 2'd1) ? AUX_LAST : SLOT_NEGRAIL;
  assign group_first_next = (group_reg == 2'd0) ? SLOT_AUX0 : SLOT_DTEMP;
  assign found = find_slot(slot_en, ptr_reg, group_last);
  // cells and inputs cycle when bit set
  assign group_cycled = cycled_average_bit && group_reg != 2'd2;

  // samples and averaging shift per channel
  always_comb begin
    need = ovs_count;
    shift_k = ovs_code;
    // monitor enable gives two or one
    if (slot_reg == SLOT_MODULE) begin
      need = stack_voltage_monitor_enable ? 6'd2 : 6'd1;
      shift_k = stack_voltage_monitor_enable ? 3'd1 : 3'd0;
    end
  end

  assign acq_slot = (state_reg == ST_SEEK) ? found : slot_reg;
  assign acq_later = (state_reg == ST_SEEK) ? pass_reg != 6'd0 : 1'b1;

  // first and later periods chosen apart
  always_comb begin
    acq_cycles = units(ext_input_period_reg);
    if (acq_slot <= CELL_LAST) begin
      acq_cycles = (acq_later && !cycled_average_bit) ? units(13'(hv_later_period)) : units(cell_period_reg);
    end else if (acq_slot <= AUX_LAST) begin
      acq_cycles = (acq_later && !cycled_average_bit) ? units(13'(general_later_period))
                                                    : units(ext_input_period_reg);
    end else if (!acq_later) begin
      unique case (acq_slot)
        SLOT_DTEMP: acq_cycles = DTEMP_FIRST_CYC;
        SLOT_CORE: acq_cycles = CORE_FIRST_CYC;
        SLOT_ATEMP: acq_cycles = units(internal_period_reg[PER_W-1:0]);
        SLOT_REF: acq_cycles = units(internal_period_reg[PER_HI_LSB +: PER_W]);
        SLOT_MODULE: acq_cycles = units(selftest_period_reg[PER_W-1:0]);
        default: acq_cycles = units(selftest_period_reg[PER_HI_LSB +: PER_W]);
      endcase
    end else begin
      acq_cycles = (acq_slot == SLOT_CORE || acq_slot == SLOT_DTEMP) ? units(13'(general_later_period))
                                                                     : units(13'(hv_later_period));
    end
  end

  // converter code pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_meta_reg <= '0;
      adc_sync_reg <= '0;
    end else begin
      adc_meta_reg <= adc_code_in;
      adc_sync_reg <= adc_meta_reg;
    end
  end

  // running sum, mean scaled to 16 bits
  assign sum = ((pass_reg == 6'd0) ? '0 : acc_rd) + ACC_W'(adc_sync_reg);
  // single sample times four spans full scale
  assign scaled = {sum, 2'b00} >> shift_k;
  assign final_sample = pass_reg == need - 6'd1;
  assign mem_we = state_reg == ST_CONV && timer_reg == 16'h0000 && (slot_reg != SLOT_DTEMP || pass_reg == 6'd0);

  always_comb begin
    if (slot_reg == SLOT_DTEMP) begin
      mem_wd = {3'h0, adc_sync_reg, 2'b00};
    end else if (final_sample) begin
      mem_wd = scaled[ACC_W-1:0];
    end else begin
      mem_wd = sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      group_reg <= 2'd0;
      slot_reg <= 5'h00;
      ptr_reg <= 5'h00;
      pass_reg <= 6'd0;
      timer_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // fixed latency from command keeps stack aligned
          if (start_req) begin
            state_reg <= ST_SEEK;
            group_reg <= 2'd0;
            ptr_reg <= 5'h00;
            pass_reg <= 6'd0;
          end
        end
        ST_SEEK: begin
          if (found != SLOT_NONE) begin
            slot_reg <= found;
            timer_reg <= acq_cycles - 16'h0001;
            state_reg <= ST_ACQ;
          end else if (group_cycled && pass_reg != ovs_count - 6'd1) begin
            pass_reg <= pass_reg + 6'd1;
            ptr_reg <= (group_reg == 2'd0) ? 5'h00 : SLOT_AUX0;
          end else if (group_reg == 2'd2) begin
            state_reg <= ST_IDLE;
          end else begin
            group_reg <= group_reg + 2'd1;
            ptr_reg <= group_first_next;
            pass_reg <= 6'd0;
          end
        end
        ST_ACQ: begin
          if (timer_reg == 16'h0000) begin
            timer_reg <= HOLD_CYC - 16'h0001;
            state_reg <= ST_CONV;
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        ST_CONV: begin
          if (timer_reg != 16'h0000) begin
            timer_reg <= timer_reg - 16'h0001;
          end else if (group_cycled) begin
            ptr_reg <= slot_reg + 5'h01;
            state_reg <= ST_SEEK;
          end else if (!final_sample) begin
            // all samples of one channel in a row
            pass_reg <= pass_reg + 6'd1;
            timer_reg <= acq_cycles - 16'h0001;
            state_reg <= ST_ACQ;
          end else begin
            pass_reg <= 6'd0;
            ptr_reg <= slot_reg + 5'h01;
            state_reg <= ST_SEEK;
          end
        end
      endcase
    end
  end

  // ****************************************
  // result store
  // ****************************************
  logic [ACC_W-1:0] bus_rd;

  result_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_we),
    .wr_addr(slot_reg),
    .wr_data(mem_wd),
    .seq_addr(slot_reg),
    .seq_data(acc_rd),
    .bus_addr(result_index),
    .bus_data(bus_rd)
  );

  // ****************************************
  // analog side outputs
  // ****************************************
  logic [4:0] idle_slot;

  // rest on channel equal to count
  assign idle_slot = (cell_count_reg == 5'h00 || cell_count_reg > CELL_TOP) ? CELL_LAST
                                                                            : CELL_TOP - cell_count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afe_ctrl <= '0;
      cell_guard <= '0;
      busy <= 1'b0;
    end else begin
      afe_ctrl.mux_channel <= (state_reg == ST_ACQ || state_reg == ST_CONV) ? slot_reg : idle_slot;
      afe_ctrl.hold_pulse <= state_reg == ST_ACQ && timer_reg == 16'h0000;
      afe_ctrl.converting <= state_reg == ST_CONV;
      // mask faults and power down unused
      cell_guard.fault_mask <= ~cell_in_use;
      cell_guard.comparator_power <= cell_in_use;
      busy <= state_reg != ST_IDLE || start_req;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    prdata = 32'h00000000;
    if (result_hit) begin
      prdata = {16'h0000, bus_rd[15:0]};
    end else begin
      unique case (paddr)
        CMD_OFS: begin
          prdata[STAT_BUSY_BIT] = state_reg != ST_IDLE;
          prdata[STAT_SLOT_LSB +: 5] = slot_reg;
        end
        CELL_COUNT_OFS: prdata = {27'h0, cell_count_reg};
        CHAN_SEL_OFS: prdata = chan_sel_reg;
        AVG_CFG_OFS: prdata = {8'h00, averaging_config_reg};
        CELL_PER_OFS: prdata = {19'h0, cell_period_reg};
        EXT_PER_OFS: prdata = {19'h0, ext_input_period_reg};
        SELFTEST_PER_OFS: prdata = {3'h0, selftest_period_reg};
        INTERNAL_PER_OFS: prdata = {3'h0, internal_period_reg};
        SELFTEST_CFG_OFS: prdata = {31'h0, selftest_config_reg};
        POWER_CFG_OFS: prdata = {24'h0, power_config_reg};
        default: prdata = 32'h00000000;
      endcase
    end
  end

endmodule : monitor_adc_sequencer

// ---- hw/adc_seq_pkg.sv ----
// constants, layouts and types of the converter measurement sequencer
// assumes a 20 MHz pclk and an APB master with 32-bit data
package adc_seq_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOLD_TIME_NS = 3440;
  localparam logic [15:0] HOLD_CYC = 16'((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PERIOD_UNIT_NS = 200;
  localparam logic [15:0] PERIOD_UNIT_CYC = 16'(PERIOD_UNIT_NS / CLK_PERIOD_NS);
  localparam int DTEMP_FIRST_NS = 50000;
  localparam logic [15:0] DTEMP_FIRST_CYC = 16'((DTEMP_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CORE_FIRST_NS = 30000;
  localparam logic [15:0] CORE_FIRST_CYC = 16'((CORE_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] CELL_COUNT_OFS = 8'h04;
  localparam logic [7:0] CHAN_SEL_OFS = 8'h08;
  localparam logic [7:0] AVG_CFG_OFS = 8'h0C;
  localparam logic [7:0] CELL_PER_OFS = 8'h10;
  localparam logic [7:0] EXT_PER_OFS = 8'h14;
  localparam logic [7:0] SELFTEST_PER_OFS = 8'h18;
  localparam logic [7:0] INTERNAL_PER_OFS = 8'h1C;
  localparam logic [7:0] SELFTEST_CFG_OFS = 8'h20;
  localparam logic [7:0] POWER_CFG_OFS = 8'h24;
  localparam logic [7:0] RESULT_BASE_OFS = 8'h80;

  // field positions
  localparam int CMD_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLOT_LSB = 8;
  localparam int SEL_DTEMP_BIT = 8;
  localparam int SEL_ATEMP_BIT = 9;
  localparam int SEL_CORE_BIT = 10;
  localparam int SEL_REF_BIT = 11;
  localparam int SEL_MODULE_BIT = 12;
  localparam int SEL_NEGRAIL_BIT = 13;
  localparam int SEL_CELL_LSB = 16;
  localparam int AVG_CYCLE_BIT = 3;
  localparam int AVG_HV_LSB = 8;
  localparam int AVG_GEN_LSB = 16;
  localparam int PER_HI_LSB = 16;
  localparam int PER_W = 13;
  localparam int MON_EN_BIT = 0;

  // reset values
  localparam logic [4:0] CELL_COUNT_RST = 5'h10;
  localparam logic [31:0] CHAN_SEL_RST = 32'hFFFF0000;
  localparam logic [23:0] AVG_CFG_RST = 24'h3F3F00;
  localparam logic [12:0] CELL_PER_RST = 13'h012C;
  localparam logic [12:0] PER_RST = 13'h003F;
  localparam logic [7:0] POWER_CFG_RST = 8'h00;

  // sequence slots: cells 16..1, external inputs 0..7, then internal channels
  localparam int NUM_SLOTS = 30;
  localparam logic [4:0] SLOT_AUX0 = 5'h10;
  localparam logic [4:0] SLOT_DTEMP = 5'h18;
  localparam logic [4:0] SLOT_ATEMP = 5'h19;
  localparam logic [4:0] SLOT_CORE = 5'h1A;
  localparam logic [4:0] SLOT_REF = 5'h1B;
  localparam logic [4:0] SLOT_MODULE = 5'h1C;
  localparam logic [4:0] SLOT_NEGRAIL = 5'h1D;
  localparam logic [4:0] SLOT_NONE = 5'h1F;
  localparam logic [4:0] CELL_LAST = 5'h0F;
  localparam logic [4:0] AUX_LAST = 5'h17;
  localparam logic [4:0] CELL_TOP = 5'h10;
  localparam logic [2:0] OVS_MAX_CODE = 3'h5;
  localparam int ACC_W = 19;

  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_ACQ, ST_CONV} seq_state_e;

  typedef struct packed {
    logic [4:0] mux_channel;
    logic hold_pulse;
    logic converting;
  } afe_ctrl_s;

  typedef struct packed {
    logic [15:0] fault_mask;
    logic [15:0] comparator_power;
  } cell_guard_s;

endpackage : adc_seq_pkg

// ---- hw/result_store.sv ----
// result and running-sum store, one write port and two registered read ports
// assumes all ports on pclk; array contents have no reset
`timescale 1ns/1ps
module result_store
  import adc_seq_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic wr_en, // write strobe
  input wire logic [4:0] wr_addr, // write slot
  input wire logic [ACC_W-1:0] wr_data, // write word
  input wire logic [4:0] seq_addr, // sequencer read slot
  output logic [ACC_W-1:0] seq_data, // sequencer read word
  input wire logic [4:0] bus_addr, // bus read slot
  output logic [ACC_W-1:0] bus_data // bus read word
);

  logic [ACC_W-1:0] mem [0:NUM_SLOTS-1];

  always_ff @(posedge pclk) begin
    if (wr_en && wr_addr < 5'(NUM_SLOTS)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_data <= '0;
      bus_data <= '0;
    end else begin
      seq_data <= (seq_addr < 5'(NUM_SLOTS)) ? mem[seq_addr] : '0;
      bus_data <= (bus_addr < 5'(NUM_SLOTS)) ? mem[bus_addr] : '0;
    end
  end

endmodule : result_store

// ---- bench/monitor_adc_sequencer_monitor.sv ----
// port checker for the converter measurement sequencer
// assumes it is bound to monitor_adc_sequencer
`timescale 1ns/1ps
module monitor_adc_sequencer_monitor
  import adc_seq_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // error
  input wire logic [13:0] adc_code_in, // code pin
  input wire afe_ctrl_s afe_ctrl, // mux control
  input wire cell_guard_s cell_guard, // cell guard
  input wire logic busy // running
);
  // ****************************************
  // helper logic and checks
  // ****************************************
  logic up;
  logic [7:0] conv_cnt;
  logic cmd_start;
  logic bad_addr;
  assign cmd_start = psel && penable && pwrite && paddr == CMD_OFS && pwdata[CMD_START_BIT];
  assign bad_addr = (paddr > 8'h24 && paddr < 8'h80) || paddr > 8'hF4;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up <= 1'b0;
      conv_cnt <= 8'h00;
    end else begin
      up <= 1'b1;
      conv_cnt <= afe_ctrl.converting ? conv_cnt + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("ready low");
  a_hold_single: assert property (afe_ctrl.hold_pulse |=> !afe_ctrl.hold_pulse) else $error("hold long");
  a_hold_in_conv: assert property (afe_ctrl.hold_pulse |=> afe_ctrl.converting && busy)
    else $error("hold outside conversion");
  a_conv_length: assert property ($fell(afe_ctrl.converting) |-> conv_cnt == 8'(HOLD_CYC))
    else $error("conversion length wrong");
  a_guard_inverse: assert property (up |-> cell_guard.comparator_power == ~cell_guard.fault_mask)
    else $error("comparator power not inverse of mask");
  a_idle_rest: assert property (up && !busy |-> afe_ctrl.mux_channel == 5'($countones(cell_guard.fault_mask)))
    else $error("idle mux wrong");
  a_busy_start: assert property (cmd_start && !busy |-> ##[1:2] busy) else $error("start ignored");
  a_slverr_map: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == bad_addr)
    else $error("error response wrong");
endmodule : monitor_adc_sequencer_monitor

// ---- bench/afe_front_model.sv ----
// front end model: a code per slot, plus two on every other sample
// assumes sequencer control; counts clear while idle
`timescale 1ns/1ps
module afe_front_model
  import adc_seq_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire afe_ctrl_s afe_ctrl, // mux control
  input wire logic busy, // running
  output logic [13:0] adc_code_in // code pin
);
  // ****************************************
  // code source
  // ****************************************
  logic [31:0] odd_reg;
  logic [13:0] held_reg;
  logic [13:0] code;
  assign code = {3'h1, afe_ctrl.mux_channel, 6'h00} + {12'h000, odd_reg[afe_ctrl.mux_channel], 1'b0};
  // held for the hold time, inverted once released
  assign adc_code_in = afe_ctrl.hold_pulse ? code : (afe_ctrl.converting ? held_reg : ~held_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odd_reg <= '0;
      held_reg <= '0;
    end else if (!busy) begin
      odd_reg <= '0;
    end else if (afe_ctrl.hold_pulse) begin
      held_reg <= code;
      odd_reg[afe_ctrl.mux_channel] <= ~odd_reg[afe_ctrl.mux_channel];
    end
  end
endmodule : afe_front_model

// ---- bench/monitor_adc_sequencer_tb_top.sv ----
// self-checking bench for the converter measurement sequencer
// assumes the front end model and the bound port checker
`timescale 1ns/1ps
module monitor_adc_sequencer_tb_top
  import adc_seq_pkg::*;
;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [13:0] adc_code_in;
  afe_ctrl_s afe_ctrl;
  cell_guard_s cell_guard;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic rerr;
  logic [4:0] exp_q[$];
  logic [4:0] got_q[$];
  logic [4:0] sl[3] = '{5'h02, 5'h03, 5'h10};
  always #25 pclk = ~pclk;
  monitor_adc_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .adc_code_in(adc_code_in), .afe_ctrl(afe_ctrl), .cell_guard(cell_guard), .busy(busy));
  afe_front_model afe (.pclk(pclk), .presetn(presetn), .afe_ctrl(afe_ctrl), .busy(busy), .adc_code_in(adc_code_in));
  always @(posedge pclk) if (afe_ctrl.hold_pulse === 1'b1) got_q.push_back(afe_ctrl.mux_channel);
  function automatic logic [31:0] res(input logic [4:0] s, input logic [13:0] add);
    return 32'({3'h1, s, 6'h00} + add) << 2;
  endfunction : res
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic run_seq(input string what);
    got_q.delete();
    apb(1'b1, CMD_OFS, 32'h1);
    apb(1'b1, CMD_OFS, 32'h1);
    chk("busy", 32'h1, 32'(busy));
    while (busy === 1'b1) @(posedge pclk);
    chk("hold count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) chk("slot order", exp_q[i], got_q[i]);
    $display("test %s done", what);
  endtask : run_seq
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    #4600000;
    num_errors++;
    $display("BAD watchdog expected end seen hang");
    results();
  end
  initial begin
    int n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("count reset", CELL_COUNT_OFS, 32'h10);
    rdchk("select reset", CHAN_SEL_OFS, 32'hFFFF0000);
    rdchk("averaging reset", AVG_CFG_OFS, 32'h003F3F00);
    rdchk("cell period reset", CELL_PER_OFS, 32'h0000012C);
    apb(1'b1, POWER_CFG_OFS, 32'h80);
    rdchk("power config", POWER_CFG_OFS, 32'h80);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, 32'(rerr));
    apb(1'b1, CELL_COUNT_OFS, 32'h0E);
    @(posedge pclk);
    chk("cell guard", 32'hC0003FFF, cell_guard);
    chk("idle slot", 32'h2, 32'(afe_ctrl.mux_channel));
    apb(1'b1, CELL_PER_OFS, 32'h1);
    apb(1'b1, EXT_PER_OFS, 32'h1);
    apb(1'b1, CHAN_SEL_OFS, 32'h30000001);
    for (int cyc = 0; cyc < 2; cyc++) begin
      for (int f = 0; f < 6; f++) begin
        n = 1 << f;
        // hv later 63 units (12.6 us), general later 21 units (4.2 us)
        apb(1'b1, AVG_CFG_OFS, 32'h00153F00 | (cyc << 3) | f);
        exp_q.delete();
        // highest cell first; sweep or stay
        for (int i = 0; i < 2 * n; i++) exp_q.push_back(cyc ? 5'(2 + i % 2) : 5'(2 + i / n));
        for (int i = 0; i < n; i++) exp_q.push_back(5'h10);
        run_seq("averaging");
        foreach (sl[k]) rdchk("result", RESULT_BASE_OFS + 8'(4 * sl[k]), res(sl[k], 14'(f > 0)));
      end
    end
    apb(1'b1, CHAN_SEL_OFS, 32'h00001100);
    apb(1'b1, AVG_CFG_OFS, 32'h00153F01);
    for (int en = 0; en < 2; en++) begin
      apb(1'b1, SELFTEST_CFG_OFS, 32'(en));
      exp_q = '{SLOT_DTEMP, SLOT_DTEMP, SLOT_MODULE};
      if (en == 1) exp_q.push_back(SLOT_MODULE);
      run_seq("internal");
      rdchk("die temp", RESULT_BASE_OFS + 8'h60, res(SLOT_DTEMP, 14'h0));
      rdchk("module", RESULT_BASE_OFS + 8'h70, res(SLOT_MODULE, 14'(en)));
    end
    results();
  end
endmodule : monitor_adc_sequencer_tb_top
bind monitor_adc_sequencer monitor_adc_sequencer_monitor chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .adc_code_in(adc_code_in), .afe_ctrl(afe_ctrl), .cell_guard(cell_guard), .busy(busy));
